// >>> logic/rtsc_params.svh
// constants of the reset and test strap control block
// assumes a single 25 MHz clock and pins taken as synchronous to it
//
// Summary of operation
// RL1: self-configuration starts only on reset rising edge
// RL2: board releases reset after rails, clocks stable
// RL3: flash and general pins float during reset
// RL4: light selects and mirror enable low in reset
// RL5: every signal inactive while reset held
// RL6: host keeps serial bus quiet 500 ms
// RL7: test pins float, sampled 1.5 us, then driven
// RL8: test pins 0..2 feed select bits 0..2
// RL9: board never pulls test pins high when sampled; the board model pulls pins 0..2 high per pull_up_in
// RL10: board holds reserved strap low
// RL11: test pin 4 carries second output trigger
// RL12: board configures unused two-way pins as outputs
// RL13: zero select means normal, nonzero means test
`ifndef RTSC_PARAMS_SVH
`define RTSC_PARAMS_SVH

`define RTSC_CLK_HZ 25000000
`define RTSC_CLK_PERIOD_NS 40
`define RTSC_SAMPLE_DELAY_NS 1500
`define RTSC_SAMPLE_CYCLES \
    ((`RTSC_SAMPLE_DELAY_NS + `RTSC_CLK_PERIOD_NS - 1) / `RTSC_CLK_PERIOD_NS)
`define RTSC_I2C_QUIET_MS 500
`define RTSC_I2C_QUIET_CYCLES ((`RTSC_CLK_HZ / 1000) * `RTSC_I2C_QUIET_MS)
`define RTSC_GPIO_W 20
`define RTSC_TSTPT_W 8
`define RTSC_TEST_MODE_SELECT_W 3
`define RTSC_TRIG_POS 4
`define RTSC_TEST_MODE_SELECT_NORMAL 3'h0
`define RTSC_SAMPLE_CNT_W 6
`define RTSC_QUIET_CNT_W 24

`endif

// >>> logic/rtsc_pkg.sv
// types of the reset and test strap control block
// assumes rtsc_params.svh is on the include path
`include "rtsc_params.svh"

package rtsc_pkg;

    typedef enum logic [2:0] {
        RTSC_IDLE,
        RTSC_HELD,
        RTSC_WAIT,
        RTSC_SAMPLE,
        RTSC_RUN,
        RTSC_TEST
    } rtsc_state_t;

    // serial flash pin group, one enable for all four
    typedef struct packed {
        logic clk;
        logic dout;
        logic sel0_n;
        logic sel1_n;
    } rtsc_flash_t;

    // functional values the core wants on the pins once running
    typedef struct packed {
        logic light_source_select0;
        logic light_source_select1;
        logic mirror_enable_reset_n;
    } rtsc_light_t;

endpackage

// >>> logic/rtsc_top.sv
// reset sequencing and test strap sampling
// assumes all pin inputs are synchronous to clk_in and that the pads
// resolve the two-way wires from the enables
`timescale 1ns/1ps
`include "rtsc_params.svh"

module rtsc_top #(
    parameter int unsigned QUIET_CYCLES = `RTSC_I2C_QUIET_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // board reset and park inputs
    input wire logic power_on_reset_n_in,
    input wire logic mirror_park_request_n_in,
    // functional values from the core
    input wire rtsc_pkg::rtsc_flash_t flash_func_in,
    input wire logic [`RTSC_GPIO_W-1:0] gpio_func_out_in,
    input wire logic [`RTSC_GPIO_W-1:0] gpio_func_oe_in,
    input wire rtsc_pkg::rtsc_light_t light_func_in,
    input wire logic [`RTSC_TSTPT_W-1:0] test_func_in,
    input wire logic output_trigger_b_in,
    // serial flash pins
    output rtsc_pkg::rtsc_flash_t flash_out,
    output logic flash_oe_out,
    // general purpose two-way pins
    input wire logic [`RTSC_GPIO_W-1:0] general_io_pins_in,
    output logic [`RTSC_GPIO_W-1:0] general_io_pins_out,
    output logic [`RTSC_GPIO_W-1:0] general_io_pins_oe_out,
    output logic [`RTSC_GPIO_W-1:0] general_io_rd_out,
    // light select and mirror enable pins
    output rtsc_pkg::rtsc_light_t light_out,
    // test strap two-way pins
    input wire logic [`RTSC_TSTPT_W-1:0] test_strap_pins_in,
    output logic [`RTSC_TSTPT_W-1:0] test_strap_pins_out,
    output logic [`RTSC_TSTPT_W-1:0] test_strap_pins_oe_out,
    // status toward the core
    output logic [`RTSC_TEST_MODE_SELECT_W-1:0] test_mode_select_out,
    output logic normal_mode_out,
    output logic test_mode_out,
    output logic i2c_ready_out
);

    localparam logic [`RTSC_SAMPLE_CNT_W-1:0] SAMPLE_LAST =
        `RTSC_SAMPLE_CNT_W'(`RTSC_SAMPLE_CYCLES - 1);
    localparam logic [`RTSC_QUIET_CNT_W-1:0] QUIET_LAST =
        `RTSC_QUIET_CNT_W'(QUIET_CYCLES - 1);

    rtsc_pkg::rtsc_state_t state_q;
    rtsc_pkg::rtsc_state_t state_d;
    logic por_prev_q;
    logic por_rise;
    logic [`RTSC_SAMPLE_CNT_W-1:0] sample_cnt_q;
    logic [`RTSC_QUIET_CNT_W-1:0] quiet_cnt_q;
    logic quiet_done_q;
    logic [`RTSC_TEST_MODE_SELECT_W-1:0] test_mode_select_q;
    logic drive_func;
    logic drive_test;

    // previous level reset high, so a board reset already high at our
    // own reset release never starts configuration without a real edge
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            por_prev_q <= 1'b1;
        else
            por_prev_q <= power_on_reset_n_in;
    end

    assign por_rise = power_on_reset_n_in && !por_prev_q; // [RL1]

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            rtsc_pkg::RTSC_IDLE,
            rtsc_pkg::RTSC_HELD:
            begin
                if (por_rise)
                    state_d = rtsc_pkg::RTSC_WAIT; // [RL1]
                else if (!power_on_reset_n_in)
                    state_d = rtsc_pkg::RTSC_HELD;
            end
            rtsc_pkg::RTSC_WAIT:
            begin
                if (sample_cnt_q == SAMPLE_LAST)
                    state_d = rtsc_pkg::RTSC_SAMPLE; // [RL7]
            end
            rtsc_pkg::RTSC_SAMPLE:
            begin
                if (test_strap_pins_in[`RTSC_TEST_MODE_SELECT_W-1:0] ==
                    `RTSC_TEST_MODE_SELECT_NORMAL)
                    state_d = rtsc_pkg::RTSC_RUN; // [RL13]
                else
                    state_d = rtsc_pkg::RTSC_TEST; // [RL13]
            end
            rtsc_pkg::RTSC_RUN,
            rtsc_pkg::RTSC_TEST:
            begin
                state_d = state_q;
            end
        endcase
        // reset low overrides every state
        if (!power_on_reset_n_in)
            state_d = rtsc_pkg::RTSC_HELD; // [RL5]
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_q <= rtsc_pkg::RTSC_IDLE;
        else
            state_q <= state_d;
    end

    // delay from reset release to the strap sample
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            sample_cnt_q <= '0;
        else if (state_q == rtsc_pkg::RTSC_WAIT)
            sample_cnt_q <= sample_cnt_q + 1'b1; // [RL7]
        else
            sample_cnt_q <= '0;
    end

    // one-time strap capture; held until the next board reset
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            test_mode_select_q <= `RTSC_TEST_MODE_SELECT_NORMAL;
        else if (state_q == rtsc_pkg::RTSC_SAMPLE)
            test_mode_select_q <= test_strap_pins_in[`RTSC_TEST_MODE_SELECT_W-1:0]; // [RL8]
        else if (state_q == rtsc_pkg::RTSC_HELD)
            test_mode_select_q <= `RTSC_TEST_MODE_SELECT_NORMAL;
    end

    // quiet period for the host's serial bus; only a status hint, the
    // block does not police bus traffic itself
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            quiet_cnt_q <= '0;
            quiet_done_q <= 1'b0;
        end
        else if (!power_on_reset_n_in || !mirror_park_request_n_in ||
                 state_q == rtsc_pkg::RTSC_IDLE)
        begin
            quiet_cnt_q <= '0;
            quiet_done_q <= 1'b0;
        end
        else if (!quiet_done_q)
        begin
            if (quiet_cnt_q == QUIET_LAST)
                quiet_done_q <= 1'b1; // [RL6]
            else
                quiet_cnt_q <= quiet_cnt_q + 1'b1;
        end
    end

    // test mode keeps the functional pins parked; test pins still drive
    assign drive_func = (state_d == rtsc_pkg::RTSC_RUN);
    assign drive_test = (state_d == rtsc_pkg::RTSC_RUN) ||
                        (state_d == rtsc_pkg::RTSC_TEST);

    // serial flash and general pins
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !drive_func)
        begin
            flash_out <= '0;
            flash_oe_out <= 1'b0; // [RL3]
            general_io_pins_out <= '0;
            general_io_pins_oe_out <= '0; // [RL3]
        end
        else
        begin
            flash_out <= flash_func_in;
            flash_oe_out <= 1'b1;
            general_io_pins_out <= gpio_func_out_in;
            general_io_pins_oe_out <= gpio_func_oe_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            general_io_rd_out <= '0;
        else
            general_io_rd_out <= general_io_pins_in;
    end

    // light selects and mirror enable forced low until running
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !drive_func)
            light_out <= '0; // [RL4]
        else
            light_out <= light_func_in;
    end

    // test pins float until sampled, then become outputs
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !drive_test)
        begin
            test_strap_pins_out <= '0;
            test_strap_pins_oe_out <= '0; // [RL7]
        end
        else
        begin
            test_strap_pins_out <= test_func_in;
            test_strap_pins_out[`RTSC_TRIG_POS] <=
                output_trigger_b_in; // [RL11]
            test_strap_pins_oe_out <= '1; // [RL7]
        end
    end

    // status
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            test_mode_select_out <= `RTSC_TEST_MODE_SELECT_NORMAL;
            normal_mode_out <= 1'b0;
            test_mode_out <= 1'b0;
            i2c_ready_out <= 1'b0;
        end
        else
        begin
            test_mode_select_out <= test_mode_select_q;
            normal_mode_out <= (state_q == rtsc_pkg::RTSC_RUN); // [RL13]
            test_mode_out <= (state_q == rtsc_pkg::RTSC_TEST); // [RL13]
            i2c_ready_out <= quiet_done_q && power_on_reset_n_in &&
                             mirror_park_request_n_in; // [RL6]
        end
    end

endmodule

// >>> test/rtsc_monitor.sv
// checker of the reset and strap sequence at the top ports
// assumes board reset is synchronous to clk_in
`timescale 1ns/1ps
`include "rtsc_params.svh"

module rtsc_monitor (
    // clock, reset and pad inputs
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic power_on_reset_n_in,
    input wire logic [`RTSC_TSTPT_W-1:0] test_strap_pins_in,
    input wire logic output_trigger_b_in,
    // design outputs
    input wire logic flash_oe_out,
    input wire logic [`RTSC_GPIO_W-1:0] general_io_pins_oe_out,
    input wire rtsc_pkg::rtsc_light_t light_out,
    input wire logic [`RTSC_TSTPT_W-1:0] test_strap_pins_out,
    input wire logic [`RTSC_TSTPT_W-1:0] test_strap_pins_oe_out,
    input wire logic [`RTSC_TEST_MODE_SELECT_W-1:0] test_mode_select_out,
    input wire logic normal_mode_out,
    input wire logic test_mode_out,
    input wire logic i2c_ready_out
);
    // edges since reset rose; 63 also marks idle, since no rise was seen
    logic [5:0] hi_q;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            hi_q <= 6'h3f;
        else if (!power_on_reset_n_in)
            hi_q <= 6'h00;
        else if (hi_q != 6'h3f)
            hi_q <= hi_q + 6'h01;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_held_pins_float: assert property (
        !power_on_reset_n_in |=> !flash_oe_out
        && general_io_pins_oe_out == 20'h0) else $error("pins driven");
    a_held_light_low: assert property (
        !power_on_reset_n_in |=> light_out == 3'h0) else $error("light");
    a_held_all_idle: assert property (
        // select clears one edge into hold and reaches the port one later
        !power_on_reset_n_in [*3] |=> !normal_mode_out && !test_mode_out
        && !i2c_ready_out && test_mode_select_out == 3'h0) else $error("idle");
    a_start_on_rise: assert property (
        $rose(normal_mode_out) |-> hi_q == 6'h29) else $error("start");
    a_strap_capture: assert property (
        hi_q == 6'h27 && power_on_reset_n_in |-> ##2 test_mode_select_out
        == $past(test_strap_pins_in[2:0], 2)) else $error("capture");
    a_strap_float: assert property (
        hi_q <= 6'h27 |-> test_strap_pins_oe_out == 8'h00) else $error("tz");
    a_strap_driven: assert property (
        hi_q inside {[6'h28:6'h3e]} |-> test_strap_pins_oe_out == 8'hff)
        else $error("strap pins not driven");
    a_mode_by_select: assert property (
        hi_q inside {[6'h29:6'h3e]} |-> normal_mode_out ==
        (test_mode_select_out == 3'h0) && test_mode_out ==
        (test_mode_select_out != 3'h0)) else $error("mode");
    a_trigger_pin: assert property (
        hi_q inside {[6'h29:6'h3e]} |-> test_strap_pins_out[4]
        == $past(output_trigger_b_in)) else $error("trigger");
    c_normal: cover property ($rose(normal_mode_out));
    c_test: cover property ($rose(test_mode_out));
    c_abort: cover property (hi_q == 6'h14 && !power_on_reset_n_in);
endmodule

bind rtsc_top rtsc_monitor rtsc_monitor_inst (.clk_in, .rst_in,
    .power_on_reset_n_in, .test_strap_pins_in, .output_trigger_b_in,
    .flash_oe_out, .general_io_pins_oe_out, .light_out, .test_strap_pins_out,
    .test_strap_pins_oe_out, .test_mode_select_out, .normal_mode_out,
    .test_mode_out, .i2c_ready_out);

// >>> test/rtsc_board_model.sv
// board side: reset supervisor, park line and pad wiring
// assumes the bench says when rails and clocks are steady
`timescale 1ns/1ps
`include "rtsc_params.svh"

module rtsc_board_model (
    // clock and bench commands
    input wire logic clk_in,
    input wire logic release_in,
    input wire logic [`RTSC_TEST_MODE_SELECT_W-1:0] pull_up_in,
    // device pins
    input wire logic [`RTSC_TSTPT_W-1:0] strap_out_in,
    input wire logic [`RTSC_TSTPT_W-1:0] strap_oe_in,
    input wire logic [`RTSC_GPIO_W-1:0] gpio_out_in,
    input wire logic [`RTSC_GPIO_W-1:0] gpio_oe_in,
    output logic power_on_reset_n_out,
    output logic mirror_park_request_n_out,
    output logic [`RTSC_TSTPT_W-1:0] strap_pad_out,
    output logic [`RTSC_GPIO_W-1:0] gpio_pad_out
);
    // reset released only once supplies are declared steady
    always_ff @(posedge clk_in)
        power_on_reset_n_out <= release_in;
    // reserved strap has only the pull-down on this board, so it reads low at
    // the block whenever it floats
    // park high; this model never starts a serial bus transfer
    assign mirror_park_request_n_out = 1'b1;
    // floating straps sit on the pull-down unless a pull-up is fitted
    assign strap_pad_out = (strap_out_in & strap_oe_in)
        | (~strap_oe_in & {5'h00, pull_up_in});
    // spare two-way pins pulled low, so a float reads 0
    assign gpio_pad_out = gpio_out_in & gpio_oe_in;
endmodule

// >>> test/rtsc_tb_top.sv
// bench for the reset and test strap control block
// assumes the board model drives reset, park and pad levels
`timescale 1ns/1ps
`include "rtsc_params.svh"

module rtsc_tb_top;
    logic clk_in;
    logic rst_in;
    logic release_q;
    logic [2:0] pull_q;
    logic [7:0] pat_q = 8'h00;
    logic por_n, park_n, flash_oe, normal, test, ready;
    logic [7:0] s_pad, s_out, s_oe;
    logic [19:0] g_pad, g_out, g_oe, g_rd;
    rtsc_pkg::rtsc_flash_t flash;
    rtsc_pkg::rtsc_light_t light;
    logic [2:0] tms;
    int n_mismatch = 0;
    int total_checks = 0;

    rtsc_top #(.QUIET_CYCLES(50)) rtsc_top_inst (.clk_in(clk_in),
        .rst_in(rst_in), .power_on_reset_n_in(por_n),
        .mirror_park_request_n_in(park_n), .flash_func_in(pat_q[3:0]),
        .gpio_func_out_in({5{pat_q[3:0]}}), .gpio_func_oe_in({5{pat_q[7:4]}}),
        .light_func_in(pat_q[2:0]), .test_func_in(pat_q),
        .output_trigger_b_in(pat_q[0]), .flash_out(flash),
        .flash_oe_out(flash_oe), .general_io_pins_in(g_pad),
        .general_io_pins_out(g_out), .general_io_pins_oe_out(g_oe),
        .general_io_rd_out(g_rd), .light_out(light),
        .test_strap_pins_in(s_pad),
        .test_strap_pins_out(s_out), .test_strap_pins_oe_out(s_oe),
        .test_mode_select_out(tms), .normal_mode_out(normal),
        .test_mode_out(test), .i2c_ready_out(ready));
    rtsc_board_model rtsc_board_model_inst (.clk_in(clk_in),
        .release_in(release_q), .pull_up_in(pull_q), .strap_out_in(s_out),
        .strap_oe_in(s_oe), .gpio_out_in(g_out), .gpio_oe_in(g_oe),
        .power_on_reset_n_out(por_n), .mirror_park_request_n_out(park_n),
        .strap_pad_out(s_pad), .gpio_pad_out(g_pad));

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // moving pattern so functional inputs are not frozen
    always @(posedge clk_in)
        pat_q <= pat_q + 8'h01;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic power_up(input logic [2:0] strap);
        int i;
        logic [7:0] pv;
        logic [6:0] fe;
        logic [19:0] gp;
        pull_q <= strap;
        release_q <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check({flash_oe, g_oe}, 21'h0);
        check(light, 3'h0);
        check({normal, test, tms, ready}, 6'h0);
        check(s_oe, 8'h00);
        release_q <= 1'b1;
        for (i = 0; i < 60 && normal !== 1'b1 && test !== 1'b1; i++)
            @(posedge clk_in) #1;
        if (i == 60)
        begin
            check(20'h1, 20'h0);
            end_of_test();
        end
        check(tms, strap);
        check({normal, test}, {strap == 3'h0, strap != 3'h0});
        check(flash_oe, strap == 3'h0);
        check(s_oe, 8'hff);
        // pins follow the core one flop late; functional ones only if normal
        pv = pat_q - 8'h01;
        fe = (strap == 3'h0) ? {pv[3:0], pv[2:0]} : 7'h00;
        check({flash, light, s_out}, {fe, pv[7:5], pv[0], pv[3:0]});
        check(g_out, (strap == 3'h0) ? {5{pv[3:0]}} : 20'h0);
        check(g_oe, (strap == 3'h0) ? {5{pv[7:4]}} : 20'h0);
        check(ready, 1'b0);
        gp = g_pad;
        @(posedge clk_in) #1;
        check(g_rd, gp);
        repeat (11) @(posedge clk_in);
        #1;
        check(ready, 1'b1);
    endtask

    task automatic abort_seq();
        pull_q <= 3'h0;
        release_q <= 1'b0;
        repeat (4) @(posedge clk_in);
        release_q <= 1'b1;
        repeat (20) @(posedge clk_in);
        release_q <= 1'b0;
        repeat (2) @(posedge clk_in);
        release_q <= 1'b1;
        repeat (30) @(posedge clk_in);
        #1;
        check(normal, 1'b0);
    endtask

    task automatic no_rise();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (50) @(posedge clk_in);
        #1;
        check({flash_oe, normal, test}, 3'h0);
    endtask

    initial
    begin
        rst_in = 1'b1;
        release_q = 1'b1;
        pull_q = 3'h0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int s = 0; s < 8; s++)
            power_up(s[2:0]);
        abort_seq();
        no_rise();
        end_of_test();
    end
endmodule
